// >>> shared/tcwg_pkg.sv
package tcwg_pkg;
  // ---------------------------------------------------------------------------
  // widths and extreme values
  // ---------------------------------------------------------------------------
  localparam int TCWG_CNT_W = 8;
  localparam logic [7:0] TCWG_BOTTOM = 8'h00;
  localparam logic [7:0] TCWG_MAX = 8'hff;

  // ---------------------------------------------------------------------------
  // waveform mode field encoding
  // ---------------------------------------------------------------------------
  localparam logic [1:0] TCWG_WM_NORMAL = 2'h0;
  localparam logic [1:0] TCWG_WM_PHASE = 2'h1;
  localparam logic [1:0] TCWG_WM_CLEAR = 2'h2;
  localparam logic [1:0] TCWG_WM_FAST = 2'h3;

  // ---------------------------------------------------------------------------
  // output action field encoding
  // ---------------------------------------------------------------------------
  localparam logic [1:0] TCWG_OA_NONE = 2'h0;
  localparam logic [1:0] TCWG_OA_TOGGLE = 2'h1;
  localparam logic [1:0] TCWG_OA_CLEAR = 2'h2;
  localparam logic [1:0] TCWG_OA_SET = 2'h3;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] TCWG_CNT_RST = 8'h00;
  localparam logic [1:0] TCWG_FIELD_RST = 2'h0;
  localparam logic TCWG_BIT_RST = 1'b0;

  typedef enum logic [1:0] {
    TCWG_ACT_HOLD,
    TCWG_ACT_CLR,
    TCWG_ACT_SET,
    TCWG_ACT_TGL
  } tcwg_act_t;
endpackage : tcwg_pkg

// >>> design/tcwg_out_action.sv
`timescale 1ns/1ns
// maps the output action field and current event to an action on the output state
module tcwg_out_action
  import tcwg_pkg::*;
(
  // ---------------------------------------------------------------------------
  // control
  // ---------------------------------------------------------------------------
  input wire logic [1:0] mode,
  input wire logic [1:0] action,
  // ---------------------------------------------------------------------------
  // events
  // ---------------------------------------------------------------------------
  input wire logic match_ev,
  input wire logic force_ev,
  input wire logic wrap_ev,
  output tcwg_act_t act
);
  logic is_pwm;

  assign is_pwm = mode[0];

  always_comb begin
    act = TCWG_ACT_HOLD;
    if (action != TCWG_OA_NONE) begin
      if (!is_pwm) begin
        if (match_ev || force_ev) begin
          case (action)
            TCWG_OA_TOGGLE: act = TCWG_ACT_TGL;
            TCWG_OA_CLEAR: act = TCWG_ACT_CLR;
            TCWG_OA_SET: act = TCWG_ACT_SET;
            default: act = TCWG_ACT_HOLD;
          endcase
        end
      end else if (mode == TCWG_WM_FAST) begin
        // match and wrap meet only with compare at max: match wins, giving a steady level
        if (action == TCWG_OA_TOGGLE) begin
          if (match_ev) act = TCWG_ACT_TGL;
        end else if (match_ev) begin
          act = (action == TCWG_OA_CLEAR) ? TCWG_ACT_CLR : TCWG_ACT_SET;
        end else if (wrap_ev) begin
          act = (action == TCWG_OA_CLEAR) ? TCWG_ACT_SET : TCWG_ACT_CLR;
        end
      end
    end
  end
endmodule : tcwg_out_action

// >>> design/tcwg_timer.sv
`timescale 1ns/1ns
// -----------------------------------------------------------------------------
// How it works
// - timer count write blocks next-tick matches
// - output state kept across mode changes
// - output action field applies immediately
// - nonzero action overrides port output value
// - direction bit still controls pin drive
// - action zero leaves output state alone
// - force strobe applies action outside pwm
// - counting depends only on mode field
// - normal mode increments, wraps ff to 00
// - normal overflow flag set when count zero
// - normal mode accepts count writes anytime
// - clear mode resets count at compare
// - clear mode sets match flag at top
// - clear mode compare value is unbuffered
// - clear mode toggle gives divided clock
// - clear mode overflow on max to zero
// - fast pwm counts zero to max, wraps
// - fast pwm action 2/3 polarity behaviour
// - fast pwm overflow at maximum
// - fast pwm extreme compare values behave
// - fast pwm toggle, compare stays buffered
// - match flag next tick, write-one clears
// - pwm compare buffered, updates at bottom in fast pwm only
// - force sets no flag, touches no counter
// - count write beats clear and increment
// -----------------------------------------------------------------------------
module tcwg_timer
  import tcwg_pkg::*;
#(
  parameter int CNT_W = TCWG_CNT_W
) (
  // clock, reset, enable
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic CLK_EN,
  // timer tick from clock select
  input wire logic TIMER_TICK,
  // count access
  input wire logic COUNT_WR,
  input wire logic [CNT_W-1:0] COUNT_WDATA,
  output logic [CNT_W-1:0] TIMER_COUNT,
  // compare access
  input wire logic COMPARE_WR,
  input wire logic [CNT_W-1:0] COMPARE_WDATA,
  output logic [CNT_W-1:0] COMPARE_VALUE,
  // control fields
  input wire logic [1:0] WAVEFORM_MODE_FIELD,
  input wire logic [1:0] OUTPUT_ACTION_FIELD,
  input wire logic FORCE_COMPARE_STROBE,
  // flags
  input wire logic OVERFLOW_CLR,
  input wire logic MATCH_CLR,
  output logic OVERFLOW_FLAG,
  output logic COMPARE_MATCH_FLAG,
  // port pin
  input wire logic PORT_OUT_VALUE,
  input wire logic OUTPUT_PIN_DIRECTION_BIT,
  output logic PIN_OUT,
  output logic PIN_OE_N,
  output logic COMPARE_OUTPUT_STATE
);
  // ---------------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_n_ff;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] cmp_ff;
  logic [CNT_W-1:0] cmp_buf_ff;
  logic [1:0] mode_ff;
  logic [1:0] action_ff;
  logic ocs_ff;
  logic ovf_ff;
  logic ocf_ff;
  logic block_ff;
  logic match_pend_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] cnt_max;
  logic is_pwm;
  logic tick;
  logic eq;
  logic match_ev;
  logic wrap_ev;
  logic force_ev;
  logic ovf_set;
  tcwg_act_t act;

  assign cnt_max = {CNT_W{1'b1}};
  assign is_pwm = mode_ff[0];
  assign tick = CLK_EN && TIMER_TICK;
  assign eq = (cnt_ff == cmp_ff);
  // a count write just before blocks the match for this tick
  assign match_ev = tick && eq && !block_ff;
  assign wrap_ev = tick && !COUNT_WR && (mode_ff == TCWG_WM_FAST) && (cnt_ff == cnt_max);
  assign force_ev = CLK_EN && FORCE_COMPARE_STROBE && !is_pwm;

  // ---------------------------------------------------------------------------
  // control fields: unbuffered, picked up at once
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      mode_ff <= TCWG_FIELD_RST;
      action_ff <= TCWG_FIELD_RST;
    end else if (CLK_EN) begin
      mode_ff <= WAVEFORM_MODE_FIELD;
      action_ff <= OUTPUT_ACTION_FIELD;
    end
  end

  // ---------------------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_cnt = cnt_ff;
    if (COUNT_WR) begin
      nxt_cnt = COUNT_WDATA;
    end else if (tick) begin
      case (mode_ff)
        // a blocked match must not clear the counter either
        TCWG_WM_CLEAR: nxt_cnt = (eq && !block_ff) ? TCWG_CNT_RST : cnt_ff + 1'b1;
        TCWG_WM_FAST: nxt_cnt = cnt_ff + 1'b1;
        default: nxt_cnt = cnt_ff + 1'b1;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cnt_ff <= TCWG_CNT_RST;
    end else if (CLK_EN) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // block stays armed until the next tick, even while the timer is stopped
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      block_ff <= TCWG_BIT_RST;
    end else if (CLK_EN) begin
      if (COUNT_WR) block_ff <= 1'b1;
      else if (tick) block_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // compare value: direct outside pwm, buffered until bottom in fast pwm, held in phase pwm
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cmp_ff <= TCWG_CNT_RST;
      cmp_buf_ff <= TCWG_CNT_RST;
    end else if (CLK_EN) begin
      if (COMPARE_WR) cmp_buf_ff <= COMPARE_WDATA;
      if (!is_pwm) begin
        if (COMPARE_WR) cmp_ff <= COMPARE_WDATA;
      end else if (wrap_ev) begin
        cmp_ff <= COMPARE_WR ? COMPARE_WDATA : cmp_buf_ff;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // flags: set wins over clear
  // ---------------------------------------------------------------------------
  // overflow when the count moves max to zero, counting mode 0/2/3 alike
  assign ovf_set = tick && !COUNT_WR && (nxt_cnt == TCWG_BOTTOM) && (cnt_ff == cnt_max)
    && (mode_ff != TCWG_WM_PHASE);

  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ovf_ff <= TCWG_BIT_RST;
    end else if (CLK_EN) begin
      if (ovf_set) ovf_ff <= 1'b1;
      else if (OVERFLOW_CLR) ovf_ff <= 1'b0;
    end
  end

  // flag rises one tick after the equality was seen
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      match_pend_ff <= TCWG_BIT_RST;
      ocf_ff <= TCWG_BIT_RST;
    end else if (CLK_EN) begin
      if (match_ev) match_pend_ff <= 1'b1;
      else if (tick) match_pend_ff <= 1'b0;
      if (tick && match_pend_ff) ocf_ff <= 1'b1;
      else if (MATCH_CLR) ocf_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // output state
  // ---------------------------------------------------------------------------
  tcwg_out_action u_act (
    .mode(mode_ff),
    .action(action_ff),
    .match_ev(match_ev),
    .force_ev(force_ev),
    .wrap_ev(wrap_ev),
    .act(act)
  );

  // mode changes never touch this flop, so its value survives them
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ocs_ff <= TCWG_BIT_RST;
    end else if (CLK_EN) begin
      case (act)
        TCWG_ACT_CLR: ocs_ff <= 1'b0;
        TCWG_ACT_SET: ocs_ff <= 1'b1;
        TCWG_ACT_TGL: ocs_ff <= !ocs_ff;
        default: ocs_ff <= ocs_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // pin mux: override value, direction stays with the port
  // ---------------------------------------------------------------------------
  // frozen with the rest of the state while the enable is low
  always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      PIN_OUT <= TCWG_BIT_RST;
    end else if (CLK_EN) begin
      PIN_OUT <= (action_ff != TCWG_OA_NONE) ? ocs_ff : PORT_OUT_VALUE;
    end
  end

  assign PIN_OE_N = !OUTPUT_PIN_DIRECTION_BIT;
  assign TIMER_COUNT = cnt_ff;
  assign COMPARE_VALUE = cmp_ff;
  assign OVERFLOW_FLAG = ovf_ff;
  assign COMPARE_MATCH_FLAG = ocf_ff;
  assign COMPARE_OUTPUT_STATE = ocs_ff;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  // checks share the internal reset so a partly released block never trips them
  a_write_blocks: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && COUNT_WR ##1 tick |-> !match_ev)
    else $error("match not blocked after count write");
  a_count_wr_wins: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && COUNT_WR |=> cnt_ff == $past(COUNT_WDATA))
    else $error("count write lost");
  a_hold_no_tick: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    !tick && !COUNT_WR |=> cnt_ff == $past(cnt_ff))
    else $error("count moved without tick");

  // ---------------------------------------------------------------------------
  // checks: counting sequence per mode
  // ---------------------------------------------------------------------------
  a_normal_count: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    tick && !COUNT_WR && mode_ff == TCWG_WM_NORMAL |=> cnt_ff == $past(cnt_ff) + 1'b1)
    else $error("normal mode did not count up");
  a_normal_wrap: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    tick && !COUNT_WR && mode_ff == TCWG_WM_NORMAL && cnt_ff == TCWG_MAX
    |=> cnt_ff == TCWG_BOTTOM && ovf_ff)
    else $error("normal overflow wrong");
  a_clear_top: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    match_ev && !COUNT_WR && mode_ff == TCWG_WM_CLEAR |=> cnt_ff == TCWG_BOTTOM)
    else $error("clear mode did not clear");
  a_clear_ovf: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    tick && !COUNT_WR && mode_ff == TCWG_WM_CLEAR && cnt_ff == TCWG_MAX
    |=> cnt_ff == TCWG_BOTTOM && ovf_ff)
    else $error("clear mode overflow wrong");
  a_fast_ovf: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    wrap_ev |=> cnt_ff == TCWG_BOTTOM && ovf_ff)
    else $error("fast pwm overflow wrong");

  // ---------------------------------------------------------------------------
  // checks: flags and compare value
  // ---------------------------------------------------------------------------
  a_flag_next: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    match_ev ##1 tick |=> ocf_ff)
    else $error("match flag not set");
  a_force_no_flag: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    force_ev && !match_pend_ff && !ocf_ff |=> !ocf_ff)
    else $error("forced compare set the match flag");
  a_force_no_count: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    force_ev && !tick && !COUNT_WR |=> cnt_ff == $past(cnt_ff))
    else $error("forced compare moved the counter");
  a_ovf_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && OVERFLOW_CLR && !ovf_set |=> !ovf_ff)
    else $error("overflow flag not cleared");
  // a glitch here would give an odd-length pwm pulse
  a_pwm_buffered: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && is_pwm && !wrap_ev |=> cmp_ff == $past(cmp_ff))
    else $error("pwm compare changed away from bottom");
  a_direct_compare: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && !is_pwm && COMPARE_WR |=> cmp_ff == $past(COMPARE_WDATA))
    else $error("compare write not direct");

  // ---------------------------------------------------------------------------
  // checks: output state and pin
  // ---------------------------------------------------------------------------
  a_action_zero: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && action_ff == TCWG_OA_NONE |=> ocs_ff == $past(ocs_ff))
    else $error("output state moved with action zero");
  a_ctc_toggle: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    match_ev && mode_ff == TCWG_WM_CLEAR && action_ff == TCWG_OA_TOGGLE
    |=> ocs_ff != $past(ocs_ff))
    else $error("clear mode did not toggle");
  a_force_pwm_off: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && FORCE_COMPARE_STROBE && is_pwm && !match_ev && !wrap_ev
    |=> ocs_ff == $past(ocs_ff))
    else $error("force acted in pwm mode");
  a_fast_match_clear: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    match_ev && mode_ff == TCWG_WM_FAST && action_ff == TCWG_OA_CLEAR |=> !ocs_ff)
    else $error("fast pwm not cleared at match");
  a_fast_wrap_set: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && wrap_ev && !match_ev && action_ff == TCWG_OA_CLEAR |=> ocs_ff)
    else $error("fast pwm not set at bottom");
  a_pin_override: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && action_ff != TCWG_OA_NONE |=> PIN_OUT == $past(ocs_ff))
    else $error("pin not overridden");
  a_pin_port: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff)
    CLK_EN && action_ff == TCWG_OA_NONE |=> PIN_OUT == $past(PORT_OUT_VALUE))
    else $error("pin lost the port value");

  c_force: cover property (@(posedge CLK_SYS) force_ev && action_ff == TCWG_OA_SET);
  c_clear_match: cover property (@(posedge CLK_SYS) match_ev && mode_ff == TCWG_WM_CLEAR);
  c_fast_wrap: cover property (@(posedge CLK_SYS) wrap_ev);
  c_blocked: cover property (@(posedge CLK_SYS) tick && eq && block_ff);
  c_spike: cover property (@(posedge CLK_SYS) match_ev && mode_ff == TCWG_WM_FAST
    && cmp_ff == TCWG_BOTTOM);
endmodule : tcwg_timer

// >>> testbench/tcwg_pin_model.sv
`timescale 1ns/1ns
module tcwg_pin_model (
  // pin drive from the timer
  input wire logic clk,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  // level seen on the board
  output logic pin_level
);
  logic float_ff = 1'b0;
  // released pin wanders so a stale driven value can never pass
  always_ff @(posedge clk) begin
    float_ff <= ~float_ff;
  end
  assign pin_level = pin_oe_n ? float_ff : pin_out;
endmodule : tcwg_pin_model

// >>> testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import tcwg_pkg::*;
  logic clk_sys, resetn, clk_en, tick, count_wr, cmp_wr, force_s, ovf_clr, m_clr;
  logic [7:0] count_wdata, count, cmp_wdata, cmp;
  logic [1:0] mode, action;
  logic ovf, mf, port, dir, pin_out, oe_n, cos, pin_level;
  int failures = 0;
  int tests_run = 0;
  int hi, hi2;
  bit ok, saw_ff;
  // ---------------------------------------------------------------------------
  // pin mux table: action, direction, port value, expected enable, level
  // ---------------------------------------------------------------------------
  typedef struct {logic [1:0] a; logic d; logic p; logic oe; logic lv;} tcwg_row_t;
  tcwg_row_t rows [5] = '{'{2'h0, 1, 1, 0, 1}, '{2'h0, 1, 0, 0, 0},
    '{2'h1, 1, 1, 0, 0}, '{2'h2, 0, 1, 1, 0}, '{2'h3, 1, 1, 0, 0}};

  tcwg_timer u_tcwg_timer (.CLK_SYS(clk_sys), .RESETN(resetn), .CLK_EN(clk_en),
    .TIMER_TICK(tick), .COUNT_WR(count_wr), .COUNT_WDATA(count_wdata), .TIMER_COUNT(count),
    .COMPARE_WR(cmp_wr), .COMPARE_WDATA(cmp_wdata), .COMPARE_VALUE(cmp),
    .WAVEFORM_MODE_FIELD(mode), .OUTPUT_ACTION_FIELD(action), .FORCE_COMPARE_STROBE(force_s),
    .OVERFLOW_CLR(ovf_clr), .MATCH_CLR(m_clr), .OVERFLOW_FLAG(ovf), .COMPARE_MATCH_FLAG(mf),
    .PORT_OUT_VALUE(port), .OUTPUT_PIN_DIRECTION_BIT(dir), .PIN_OUT(pin_out),
    .PIN_OE_N(oe_n), .COMPARE_OUTPUT_STATE(cos));
  tcwg_pin_model u_tcwg_pin_model (.clk(clk_sys), .pin_out(pin_out), .pin_oe_n(oe_n),
    .pin_level(pin_level));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic check(input logic c, input string msg);
    tests_run++;
    if (c !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  task automatic wr_count(input logic [7:0] v);
    count_wr = 1'b1;
    count_wdata = v;
    cyc(1);
    count_wr = 1'b0;
  endtask : wr_count
  task automatic wr_cmp(input logic [7:0] v);
    cmp_wr = 1'b1;
    cmp_wdata = v;
    cyc(1);
    cmp_wr = 1'b0;
  endtask : wr_cmp
  task automatic pulse_force();
    force_s = 1'b1;
    cyc(1);
    force_s = 1'b0;
    cyc(3);
  endtask : pulse_force
  task automatic clr_flags();
    ovf_clr = 1'b1;
    m_clr = 1'b1;
    cyc(1);
    ovf_clr = 1'b0;
    m_clr = 1'b0;
  endtask : clr_flags
  task automatic wait_count(input logic [7:0] v, output bit found);
    found = 0;
    for (int i = 0; i < 600 && !found; i++) begin
      cyc(1);
      if (count === v) found = 1;
    end
  endtask : wait_count
  // count output-state highs over one pwm period, starting at bottom
  task automatic period(output int h, output bit ff);
    h = 0;
    ff = 0;
    repeat (256) begin
      cyc(1);
      if (cos === 1'b1) h++;
      if (count === 8'hff) ff = 1;
    end
  endtask : period
  task automatic give_verdict();
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    #40000;
    failures++;
    give_verdict();
  end

  initial begin
    {resetn, tick, count_wr, cmp_wr, force_s, ovf_clr, m_clr, port, dir} = '0;
    {count_wdata, cmp_wdata, mode, action} = '0;
    clk_en = 1'b1;
    cyc(6);
    resetn = 1'b1;
    cyc(3);
    check(count === 8'h00 && cmp === 8'h00 && ovf === 1'b0 && mf === 1'b0, "reset regs");
    check(cos === 1'b0 && oe_n === 1'b1, "reset pin");
    foreach (rows[i]) begin
      action = rows[i].a;
      dir = rows[i].d;
      port = rows[i].p;
      cyc(3);
      check(oe_n === rows[i].oe, "pin enable");
      if (rows[i].d) check(pin_level === rows[i].lv, "pin level");
    end
    // -------------------------------------------------------------------------
    // forced compare, mode switch
    // -------------------------------------------------------------------------
    action = TCWG_OA_SET;
    dir = 1'b1;
    port = 1'b0;
    cyc(2);
    pulse_force();
    check(cos === 1'b1 && mf === 1'b0 && count === 8'h00, "force set");
    check(pin_level === 1'b1, "override");
    mode = TCWG_WM_FAST;
    action = TCWG_OA_TOGGLE;
    cyc(2);
    check(cos === 1'b1, "mode switch");
    pulse_force();
    check(cos === 1'b1, "force in pwm");
    mode = TCWG_WM_PHASE;
    cyc(2);
    pulse_force();
    check(cos === 1'b1, "force in phase pwm");
    mode = TCWG_WM_NORMAL;
    cyc(2);
    pulse_force();
    check(cos === 1'b0, "force toggle");
    action = TCWG_OA_NONE;
    // -------------------------------------------------------------------------
    // write blocking, tick gating, normal wrap
    // -------------------------------------------------------------------------
    wr_cmp(8'h05);
    wr_count(8'h05);
    cyc(2);
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(3);
    check(count === 8'h06 && mf === 1'b0, "match blocked");
    clk_en = 1'b0;
    tick = 1'b1;
    cyc(3);
    check(count === 8'h06, "enable low freezes");
    clk_en = 1'b1;
    wr_count(8'hfd);
    check(count === 8'hfd, "write wins");
    wait_count(8'h00, ok);
    check(ok && ovf === 1'b1, "normal overflow");
    wait_count(8'h06, ok);
    cyc(1);
    check(ok && mf === 1'b1 && cos === 1'b0, "match flag");
    clr_flags();
    check(mf === 1'b0 && ovf === 1'b0, "flag clear");
    // -------------------------------------------------------------------------
    // clear on match
    // -------------------------------------------------------------------------
    mode = TCWG_WM_CLEAR;
    action = TCWG_OA_TOGGLE;
    wr_cmp(8'h03);
    wr_count(8'h00);
    hi = 0;
    hi2 = 0;
    repeat (40) begin
      cyc(1);
      if (count > hi) hi = count;
      if (cos !== pin_out) hi2++;
    end
    check(hi == 3 && mf === 1'b1, "clear top");
    check(hi2 >= 8, "toggle rate");
    tick = 1'b0;
    clr_flags();
    wr_count(8'h0a);
    tick = 1'b1;
    wait_count(8'hff, ok);
    check(ok, "missed match runs to max");
    cyc(1);
    check(count === 8'h00 && ovf === 1'b1, "clear overflow");
    // -------------------------------------------------------------------------
    // fast pwm
    // -------------------------------------------------------------------------
    mode = TCWG_WM_FAST;
    action = TCWG_OA_CLEAR;
    wait_count(8'h10, ok);
    wr_cmp(8'h80);
    cyc(2);
    check(cmp === 8'h03, "compare buffered");
    clr_flags();
    wait_count(8'h01, ok);
    check(ok && cmp === 8'h80 && ovf === 1'b1, "buffer load");
    wait_count(8'h00, ok);
    period(hi, saw_ff);
    check(saw_ff && count === 8'h00, "single slope");
    check(hi >= 127 && hi <= 130, "duty");
    action = TCWG_OA_SET;
    wait_count(8'h00, ok);
    period(hi2, saw_ff);
    check(hi + hi2 == 256, "inverted duty");
    wr_cmp(8'h00);
    wait_count(8'h00, ok);
    wait_count(8'h00, ok);
    period(hi, saw_ff);
    check(hi >= 254 && hi <= 255, "bottom spike");
    give_verdict();
  end
endmodule : testbench
